// ===== ptmr_regs.vh
// Register map, field positions and reset values of the paired timer.
`ifndef PTMR_REGS_VH
`define PTMR_REGS_VH
`define PTMR_LO_CTRL   8'h00
`define PTMR_HI_CTRL   8'h04
`define PTMR_LO_COUNT  8'h08
`define PTMR_HI_COUNT  8'h0c
`define PTMR_LO_PERIOD 8'h10
`define PTMR_HI_PERIOD 8'h14
`define PTMR_STATUS    8'h18
`define PTMR_MASK      8'h1c
`define PTMR_LO_WMASK  16'ha37a
`define PTMR_HI_WMASK  16'ha372
`define PTMR_CTRL_RST  16'h0000
`define PTMR_DIV256_LAST 8'hff
`define PTMR_DIV64_LAST  8'h3f
`define PTMR_DIV8_LAST   8'h07
`define PTMR_DIV1_LAST   8'h00
`define PTMR_PER_RST   16'hffff
`define PTMR_BIT_RUN   15
`define PTMR_BIT_IDLE  13
`define PTMR_BIT_GATE  6
`define PTMR_BIT_WIDE  3
`define PTMR_BIT_CSRC  1
`define PTMR_ST_LO     0
`define PTMR_ST_HI     1
`endif

// ===== ptmr_top.v
// Paired 16/32-bit timer with an AHB-Lite register slave.
//
// Implementation choices: the address map and register access over AHB-Lite.
`include "ptmr_regs.vh"
module ptmr_top
(
  input  wire        i_clock,
  input  wire        i_sys_rst,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  input  wire        i_idle_mode,
  input  wire        i_generic_ext_clock_pin,
  input  wire        i_own_ext_clock_pin,
  input  wire        i_low_power_rc_osc,
  input  wire        i_secondary_osc,
  input  wire        i_gate_pin,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  output reg         o_irq,
  output reg         o_adc_trigger
);
  reg        phase_reg;
  reg        wr_reg;
  reg [7:0]  addr_reg;
  reg [15:0] lo_ctrl_reg;
  reg [15:0] hi_ctrl_reg;
  reg [15:0] lo_cnt_reg;
  reg [15:0] hi_cnt_reg;
  reg [15:0] lo_per_reg;
  reg [15:0] hi_per_reg;
  reg [7:0]  lo_pre_reg;
  reg [7:0]  hi_pre_reg;
  reg [1:0]  status_reg;
  reg [1:0]  mask_reg;
  reg        lo_match_reg;
  reg        hi_match_reg;
  reg [4:0]  src_prev_reg;
  reg        tick_clk_reg;
  reg [1:0]  status_next;
  reg [31:0] rd_next;
  wire       wide;
  wire       lo_edge;
  wire       hi_edge;
  wire       lo_tick;
  wire       hi_tick;
  wire       lo_hit;
  wire       hi_hit;
  wire       w_lo_ctrl;
  wire       w_hi_ctrl;
  wire [4:0] src_now;
  wire       w_lo_cnt;
  wire       w_hi_cnt;
  wire       w_lo_per;
  wire       w_hi_per;
  wire       w_status;
  wire       w_mask;
  wire       lo_live;
  wire       hi_live;
  wire       bus_take;

  // Data-phase write strobe for one word offset.
  function ptmr_wr_hit;
    input       phase;
    input       write;
    input [7:0] addr;
    input [7:0] target;
    begin
      ptmr_wr_hit = phase & write & (addr == target);
    end
  endfunction

  // A timer advances only while running and not held by idle stop.
  function ptmr_live;
    input [15:0] ctrl;
    input        idle;
    begin
      ptmr_live = ctrl[`PTMR_BIT_RUN]
                  & ~(ctrl[`PTMR_BIT_IDLE] & idle);
    end
  endfunction

  // Prescale terminal count for a code.
  function [7:0] ptmr_div_last;
    input [1:0] code;
    begin
      case (code)
        2'b11:   ptmr_div_last = `PTMR_DIV256_LAST;
        2'b10:   ptmr_div_last = `PTMR_DIV64_LAST;
        2'b01:   ptmr_div_last = `PTMR_DIV8_LAST;
        default: ptmr_div_last = `PTMR_DIV1_LAST;
      endcase
    end
  endfunction

  // Count-source edge for one control word.
  function ptmr_edge;
    input [15:0] ctrl;
    input        is_lower;
    input [4:0]  now;
    input [4:0]  prev;
    input        gate;
    input        half;
    reg   [4:0]  rise;
    begin
      rise = now & ~prev;
      if (!ctrl[`PTMR_BIT_CSRC])
        ptmr_edge = half & (~ctrl[`PTMR_BIT_GATE] | gate);
      else if (!is_lower)
        ptmr_edge = rise[1];
      else
        case (ctrl[9:8])
          2'b11:   ptmr_edge = rise[0];
          2'b10:   ptmr_edge = rise[2];
          2'b01:   ptmr_edge = rise[1];
          default: ptmr_edge = rise[3];
        endcase
    end
  endfunction

  assign wide    = lo_ctrl_reg[`PTMR_BIT_WIDE];
  assign src_now = {i_gate_pin, i_secondary_osc, i_low_power_rc_osc,
                    i_own_ext_clock_pin, i_generic_ext_clock_pin};
  assign bus_take  = i_hsel & i_hready & i_htrans[1];
  assign w_lo_ctrl = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_LO_CTRL);
  assign w_hi_ctrl = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_HI_CTRL);
  assign w_lo_cnt  = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_LO_COUNT);
  assign w_hi_cnt  = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_HI_COUNT);
  assign w_lo_per  = ptmr_wr_hit(phase_reg, wr_reg, addr_reg,
                                 `PTMR_LO_PERIOD);
  assign w_hi_per  = ptmr_wr_hit(phase_reg, wr_reg, addr_reg,
                                 `PTMR_HI_PERIOD);
  assign w_status  = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_STATUS);
  assign w_mask    = ptmr_wr_hit(phase_reg, wr_reg, addr_reg, `PTMR_MASK);
  assign lo_live   = ptmr_live(lo_ctrl_reg, i_idle_mode);
  assign hi_live   = ptmr_live(hi_ctrl_reg, i_idle_mode);
  assign lo_edge = ptmr_edge(lo_ctrl_reg, 1'b1, src_now, src_prev_reg,
                             src_now[4], tick_clk_reg);
  assign hi_edge = ptmr_edge(hi_ctrl_reg, 1'b0, src_now, src_prev_reg,
                             src_now[4], tick_clk_reg);
  // Idle stop is applied here so that a stopped timer also freezes its count; the prescaler is held by its own lo_live and hi_live gate.
  assign lo_tick = lo_live & lo_edge & ~w_lo_ctrl
                   & (lo_pre_reg == ptmr_div_last(lo_ctrl_reg[5:4]));
  assign hi_tick = hi_live & hi_edge & ~w_hi_ctrl
                   & (hi_pre_reg == ptmr_div_last(hi_ctrl_reg[5:4]));
  assign lo_hit = wide ? ({hi_cnt_reg, lo_cnt_reg} == {hi_per_reg, lo_per_reg})
                       : (lo_cnt_reg == lo_per_reg);
  assign hi_hit = hi_cnt_reg == hi_per_reg;

  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tick_clk_reg <= 1'b0;
      src_prev_reg <= 5'h00;
      lo_pre_reg   <= 8'h00;
      hi_pre_reg   <= 8'h00;
    end
    else
    begin
      tick_clk_reg <= ~tick_clk_reg;
      src_prev_reg <= src_now;
      if (w_lo_ctrl & lo_ctrl_reg[`PTMR_BIT_RUN])
        lo_pre_reg <= 8'h00;
      else if (lo_live & lo_edge)
        lo_pre_reg <= lo_tick ? 8'h00 : lo_pre_reg + 8'h01;
      if (w_hi_ctrl & hi_ctrl_reg[`PTMR_BIT_RUN])
        hi_pre_reg <= 8'h00;
      else if (hi_live & hi_edge)
        hi_pre_reg <= hi_tick ? 8'h00 : hi_pre_reg + 8'h01;
    end
  end

  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lo_cnt_reg   <= 16'h0000;
      hi_cnt_reg   <= 16'h0000;
      lo_match_reg <= 1'b0;
      hi_match_reg <= 1'b0;
    end
    else
    begin
      lo_match_reg <= 1'b0;
      hi_match_reg <= 1'b0;
      if (w_lo_cnt)
        lo_cnt_reg <= i_hwdata[15:0];
      else if (lo_tick)
      begin
        lo_cnt_reg <= lo_hit ? 16'h0000 : lo_cnt_reg + 16'h0001;
        if (!wide)
          lo_match_reg <= lo_hit;
      end
      if (w_hi_cnt)
        hi_cnt_reg <= i_hwdata[15:0];
      else if (wide)
      begin
        if (lo_tick)
        begin
          if (lo_hit)
            hi_cnt_reg <= 16'h0000;
          else if (lo_cnt_reg == 16'hffff)
            hi_cnt_reg <= hi_cnt_reg + 16'h0001;
          hi_match_reg <= lo_hit;
        end
      end
      else if (hi_tick)
      begin
        hi_cnt_reg   <= hi_hit ? 16'h0000 : hi_cnt_reg + 16'h0001;
        hi_match_reg <= hi_hit;
      end
    end
  end

  always @*
  begin
    status_next = status_reg | {hi_match_reg, lo_match_reg};
    if (w_status)
      status_next = (status_reg & ~i_hwdata[1:0])
                    | {hi_match_reg, lo_match_reg};
  end

  always @*
  begin
    rd_next = 32'h0000_0000;
    case (i_haddr[7:0])
      `PTMR_LO_CTRL:   rd_next[15:0] = lo_ctrl_reg;
      `PTMR_HI_CTRL:   rd_next[15:0] = hi_ctrl_reg;
      `PTMR_LO_COUNT:  rd_next[15:0] = lo_cnt_reg;
      `PTMR_HI_COUNT:  rd_next[15:0] = hi_cnt_reg;
      `PTMR_LO_PERIOD: rd_next[15:0] = lo_per_reg;
      `PTMR_HI_PERIOD: rd_next[15:0] = hi_per_reg;
      `PTMR_STATUS:    rd_next[1:0]  = status_reg;
      `PTMR_MASK:      rd_next[1:0]  = mask_reg;
      default:         rd_next = 32'h0000_0000;
    endcase
  end

  // The slave never stalls, so the address phase is taken on every request.
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      phase_reg   <= 1'b0;
      wr_reg      <= 1'b0;
      addr_reg    <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      phase_reg   <= bus_take;
      wr_reg      <= i_hwrite;
      addr_reg    <= {i_haddr[7:2], 2'b00};
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (bus_take & ~i_hwrite)
        o_hrdata <= rd_next;
    end
  end

  // Writes land at the end of the data phase, so a read right after a write still sees the old value.
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lo_ctrl_reg <= `PTMR_CTRL_RST;
      hi_ctrl_reg <= `PTMR_CTRL_RST;
      lo_per_reg  <= `PTMR_PER_RST;
      hi_per_reg  <= `PTMR_PER_RST;
      mask_reg    <= 2'b00;
    end
    else
    begin
      if (w_lo_ctrl)
        lo_ctrl_reg <= i_hwdata[15:0] & `PTMR_LO_WMASK;
      if (w_hi_ctrl)
        hi_ctrl_reg <= i_hwdata[15:0] & `PTMR_HI_WMASK;
      if (w_lo_per)
        lo_per_reg <= i_hwdata[15:0];
      if (w_hi_per)
        hi_per_reg <= i_hwdata[15:0];
      if (w_mask)
        mask_reg <= i_hwdata[1:0];
    end
  end

  // Irq uses the flags being registered, so it rises together with them.
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      status_reg    <= 2'b00;
      o_irq         <= 1'b0;
      o_adc_trigger <= 1'b0;
    end
    else
    begin
      status_reg    <= status_next;
      o_irq         <= |(status_next & mask_reg);
      o_adc_trigger <= hi_match_reg;
    end
  end
endmodule // ptmr_top

// ===== ptmr_src_model.sv
// Count source model: four clock pins, each toggling when enabled.
module ptmr_src_model
(
  input  wire logic       i_clock,
  input  wire logic [3:0] i_enable,
  output logic      [3:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial o_pins = 4'h0;
  // Disabled pins sit low so a wrongly chosen source never counts.
  always @(posedge i_clock)
  begin
    ph     <= ph + 2'h1;
    o_pins <= i_enable & {4{ph[1]}};
  end
endmodule // ptmr_src_model

// ===== ptmr_properties.sv
// Concurrent checks on the paired timer ports.
`include "ptmr_regs.vh"
module ptmr_properties
(
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_irq,
  input wire logic        o_adc_trigger
);
  logic       wr_q;
  logic [7:0] a_q;
  logic [1:0] msk;
  wire        rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);
  // The mask is shadowed from bus writes so irq can be judged from ports.
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_q <= 1'b0;
      a_q  <= 8'h00;
      msk  <= 2'h0;
    end
    else
    begin
      if (wr_q && a_q == `PTMR_MASK)
        msk <= i_hwdata[1:0];
      wr_q <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
      a_q  <= i_haddr[7:0];
    end
  end
  ready_always_a: assert property (o_hreadyout)
    else $error("hreadyout dropped");
  resp_okay_a: assert property (!o_hresp)
    else $error("error response seen");
  trig_pulse_a: assert property (o_adc_trigger |=> !o_adc_trigger)
    else $error("trigger pulse too long");
  lo_ctrl_bits_a: assert property ($past(rd && i_haddr[7:0] ==
    `PTMR_LO_CTRL) |-> (o_hrdata & ~{16'h0, `PTMR_LO_WMASK}) == 32'h0)
    else $error("lower control reserved bit set");
  hi_ctrl_bits_a: assert property ($past(rd && i_haddr[7:0] ==
    `PTMR_HI_CTRL) |-> (o_hrdata & ~{16'h0, `PTMR_HI_WMASK}) == 32'h0)
    else $error("upper control reserved bit set");
  unmapped_zero_a: assert property ($past(rd && i_haddr[7:5] != 3'h0)
    |-> o_hrdata == 32'h0) else $error("unmapped read not zero");
  trig_irq_a: assert property (o_adc_trigger && msk[1] |-> ##[0:3] o_irq)
    else $error("unmasked match gave no irq");
  irq_mask_a: assert property (o_irq |-> msk != 2'h0 || $past(msk) != 2'h0)
    else $error("irq with all sources masked");
  cover property (o_adc_trigger);
  cover property (o_irq ##1 !o_irq);
  cover property (rd && i_haddr[7:0] == `PTMR_HI_CTRL);
endmodule // ptmr_properties
bind ptmr_top ptmr_properties u_props (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_irq(o_irq), .o_adc_trigger(o_adc_trigger));

// ===== test_paired_16_32_bit_timer.sv
// Self-checking bench for the paired timer.
`include "ptmr_regs.vh"
module test_paired_16_32_bit_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0, rst = 1'b1, rdy, irq;
  logic        hsel = 1'b0, hwrite = 1'b0, idle = 1'b0, gate = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [3:0]  en = 4'h0, pins;
  int          fail_count = 0, comparisons = 0;
  always #2 i_clock = ~i_clock;
  ptmr_src_model src (.i_clock(i_clock), .i_enable(en), .o_pins(pins));
  ptmr_top dut (.i_clock(i_clock), .i_sys_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(rdy), .i_idle_mode(idle),
    .i_generic_ext_clock_pin(pins[3]), .i_own_ext_clock_pin(pins[1]),
    .i_low_power_rc_osc(pins[2]), .i_secondary_osc(pins[0]),
    .i_gate_pin(gate), .o_hrdata(hrdata), .o_hreadyout(rdy),
    .o_hresp(), .o_irq(irq), .o_adc_trigger());
  task wrap_up;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  task chkr(input string nm, input int lo, input int hi);
    comparisons++;
    if (q < lo || q > hi || $isunknown(q))
    begin
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, q);
      fail_count++;
    end
  endtask
  task wt;
    @(posedge i_clock);
    repeat (99) if (rdy !== 1'b1) @(posedge i_clock);
    if (rdy !== 1'b1) fail_count++;
    if (rdy !== 1'b1) wrap_up;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask
  task cnt(input logic [7:0] ca, input logic [31:0] cv, input int n,
           input logic [7:0] qa);
    bus(1'b1, qa, 32'h0);
    bus(1'b1, ca, cv);
    repeat (n) @(posedge i_clock);
    bus(1'b1, ca, 32'h0);
    bus(1'b0, qa, 32'h0);
  endtask
  task t_regs;
    bus(1'b0, `PTMR_LO_CTRL, 32'h0); chk("lo_ctrl_rst", 32'h0, q);
    bus(1'b0, `PTMR_LO_PERIOD, 32'h0); chk("lo_per_rst", 32'hffff, q);
    bus(1'b0, 8'h20, 32'h0); chk("unmapped", 32'h0, q);
    bus(1'b1, `PTMR_LO_CTRL, 32'hffffffff);
    bus(1'b0, `PTMR_LO_CTRL, 32'h0); chk("lo_ctrl", 32'ha37a, q);
    bus(1'b1, `PTMR_HI_CTRL, 32'hffffffff);
    bus(1'b0, `PTMR_HI_CTRL, 32'h0); chk("hi_ctrl", 32'ha372, q);
    bus(1'b1, `PTMR_LO_CTRL, 32'h0);
    bus(1'b1, `PTMR_HI_CTRL, 32'h0);
  endtask
  task t_presc;
    int dv[4] = '{1, 8, 64, 256};
    for (int c = 0; c < 4; c++)
    begin
      cnt(`PTMR_LO_CTRL, 32'h8000 | (c << 4), 8 * dv[c], `PTMR_LO_COUNT);
      chkr("prescale", 3, 6);
    end
  endtask
  task t_ext;
    for (int c = 0; c < 4; c++)
    begin
      en <= 4'h1 << c;
      cnt(`PTMR_LO_CTRL, 32'h8042 | (c << 8), 64, `PTMR_LO_COUNT);
      chkr("ext_src", 13, 18);
    end
    en <= 4'h2;
    cnt(`PTMR_HI_CTRL, 32'h8002, 64, `PTMR_HI_COUNT);
    chkr("hi_pin", 13, 18);
    en <= 4'h0;
  endtask
  task t_gate_idle;
    cnt(`PTMR_LO_CTRL, 32'h8040, 64, `PTMR_LO_COUNT); chkr("gate_lo", 0, 0);
    gate <= 1'b1;
    cnt(`PTMR_LO_CTRL, 32'h8040, 64, `PTMR_LO_COUNT); chkr("gate_hi", 30, 36);
    idle <= 1'b1;
    cnt(`PTMR_LO_CTRL, 32'ha000, 64, `PTMR_LO_COUNT); chkr("idle_stop", 0, 0);
    cnt(`PTMR_LO_CTRL, 32'h8000, 64, `PTMR_LO_COUNT); chkr("idle_run", 30, 36);
    cnt(`PTMR_LO_CTRL, 32'h0000, 64, `PTMR_LO_COUNT); chkr("run_off", 0, 0);
  endtask
  task t_wide;
    bus(1'b1, `PTMR_MASK, 32'h2);
    bus(1'b1, `PTMR_LO_COUNT, 32'hfffe);
    bus(1'b1, `PTMR_HI_COUNT, 32'h0);
    bus(1'b1, `PTMR_LO_PERIOD, 32'h2);
    bus(1'b1, `PTMR_HI_PERIOD, 32'h1);
    bus(1'b1, `PTMR_HI_CTRL, 32'h2030);
    bus(1'b1, `PTMR_LO_CTRL, 32'h8008);
    repeat (60) if (irq !== 1'b1) @(posedge i_clock);
    chk("wide_irq", 32'h1, {31'h0, irq});
    if (irq !== 1'b1) wrap_up;
    bus(1'b1, `PTMR_LO_CTRL, 32'h0);
    bus(1'b0, `PTMR_STATUS, 32'h0); chk("wide_flag", 32'h2, q);
    bus(1'b1, `PTMR_STATUS, 32'h2);
    bus(1'b0, `PTMR_STATUS, 32'h0); chk("w1c", 32'h0, q);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask
  initial
  begin
    repeat (10) @(posedge i_clock);
    rst <= 1'b0;
    t_regs;
    t_presc;
    t_ext;
    t_gate_idle;
    t_wide;
    wrap_up;
  end
endmodule // test_paired_16_32_bit_timer
